// file: hub_cfg_regs.svh
// constants of the hub configuration and port control block
// assumes a 20 MHz mclk and a 32-bit axi4-lite register bus
`ifndef HUB_CFG_REGS_SVH
`define HUB_CFG_REGS_SVH
// geometry
`define NPORT 4
`define AXI_AW 8
`define CNT_W 20
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_LED 8'h04
`define OFF_STATUS 8'h08
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// reset values
`define CTRL_RST 32'h00000F08
`define LED_RST 32'h00000000
// control register fields
`define CTRL_PCNT_LSB 0
`define CTRL_FW_OVR_BIT 2
`define CTRL_LED_AUTO_BIT 3
`define CTRL_NR_LSB 4
`define CTRL_PWR_LSB 8
// manual indicator register fields
`define LED_GREEN_LSB 0
`define LED_AMBER_LSB 4
// port count codes and masks
`define PCNT_3 2'h1
`define PCNT_2 2'h2
`define MASK_4 4'hF
`define MASK_3 4'h7
`define MASK_2 4'h3
// timing
`define CLK_KHZ 20000
`define POR_RELEASE_US 40
`define STRAP_LATCH_US 21
`define TURN_MS 50
`define POR_CYC ((`POR_RELEASE_US * `CLK_KHZ) / 1000)
`define STRAP_CYC ((`STRAP_LATCH_US * `CLK_KHZ) / 1000)
`define TURN_CYC_DEF (`TURN_MS * `CLK_KHZ)
// pin synchroniser: {oc_n[3:0], nr[3:0], pcnt[1:0], self, gang, pgood, ext_n}
`define SYNC_W 14
`define SYNC_RST 14'h3C00
`endif

// file: hub_cfg_pkg.sv
// types of the hub configuration and port control block
// assumes hub_cfg_regs.svh is on the include path
`include "hub_cfg_regs.svh"
package hub_cfg_pkg;
  // power-on and strap sequence, one-hot
  typedef enum logic [4:0] {
    SEQ_HOLD = 5'h01,
    SEQ_POR = 5'h02,
    SEQ_STRAP = 5'h04,
    SEQ_TURN = 5'h08,
    SEQ_DRIVE = 5'h10
  } seq_state_t;
endpackage : hub_cfg_pkg

// file: pin_sync.sv
// three-stage synchroniser for asynchronous pins
// assumes mclk domain, synchronous active-high rst
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins and filtered levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r, s2_r, s3_r, dout_r, dout_nxt;

  // a bit changes once stages two and three agree
  always_comb begin
    dout_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & dout_r);
  end

  // stage registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      dout_r <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;
endmodule : pin_sync

// file: port_tt_ctrl.sv
// per-port choice between repeater and transaction translator
// assumes link speeds come from the hub core on mclk
`timescale 1ns/1ps
module port_tt_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link speeds
  input wire logic upstream_high_speed,
  input wire logic port_high_speed,
  input wire logic port_active,
  // routing
  output logic route_translator,
  output logic route_repeater
);
  logic tt_r, tt_nxt, rep_r, rep_nxt;

  // full-speed upstream repeats on every active port; high speed splits by port speed
  always_comb begin
    tt_nxt = port_active & upstream_high_speed & ~port_high_speed;
    rep_nxt = port_active & (~upstream_high_speed | port_high_speed);
  end

  // routing registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      tt_r <= 1'b0;
      rep_r <= 1'b0;
    end else begin
      tt_r <= tt_nxt;
      rep_r <= rep_nxt;
    end
  end

  assign route_translator = tt_r;
  assign route_repeater = rep_r;
endmodule : port_tt_ctrl

// file: hub_config_port_control.sv
// configuration and port control of a four-port usb hub
// assumes 20 MHz mclk, synchronous rst, axi4-lite master on mclk
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "hub_cfg_regs.svh"
module hub_config_port_control #(
  parameter int unsigned TURN_CYC = `TURN_CYC_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite write channels
  input wire logic [`AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [`AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources
  input wire logic external_reset_n,
  input wire logic core_power_good,
  output logic chip_reset,
  // straps and shared gang/suspend pin
  input wire logic gang_strap_suspend_pin_in,
  output logic gang_strap_suspend_pin_out,
  output logic gang_strap_suspend_pin_oe_n,
  input wire logic self_power_strap,
  input wire logic [1:0] port_count_strap,
  input wire logic [`NPORT-1:0] nonremovable_strap,
  // eeprom configuration
  input wire logic eeprom_cfg_valid,
  input wire logic [1:0] eeprom_port_count,
  input wire logic [`NPORT-1:0] eeprom_nonremovable,
  // hub core status
  input wire logic global_suspend,
  input wire logic wakeup_event,
  input wire logic upstream_high_speed,
  input wire logic [`NPORT-1:0] port_high_speed,
  input wire logic [`NPORT-1:0] port_enabled,
  // hub core configuration
  output logic internal_resume,
  output logic gang_mode,
  output logic self_powered,
  output logic [`NPORT-1:0] active_ports,
  output logic [`NPORT-1:0] nonremovable_ports,
  // downstream port pins
  output logic [`NPORT-1:0] port_power_enable_n,
  input wire logic [`NPORT-1:0] port_overcurrent_n,
  output logic [`NPORT-1:0] port_green_indicator,
  output logic [`NPORT-1:0] port_amber_indicator,
  // traffic routing
  output logic [`NPORT-1:0] route_translator,
  output logic [`NPORT-1:0] route_repeater
);
  // synchronised pins
  logic [`SYNC_W-1:0] sync_q;
  logic ext_n_s, pgood_s, gang_s, self_s;
  logic [1:0] pcnt_s;
  logic [`NPORT-1:0] nr_s, oc_n_s;

  pin_sync #(
    .W(`SYNC_W),
    .RST_VAL(`SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({port_overcurrent_n, nonremovable_strap, port_count_strap, self_power_strap,
          gang_strap_suspend_pin_in, core_power_good, external_reset_n}),
    .dout(sync_q)
  );
  assign {oc_n_s, nr_s, pcnt_s, self_s, gang_s, pgood_s, ext_n_s} = sync_q;

  // ---- power-on sequence and strap latch ----
  hub_cfg_pkg::seq_state_t seq_r, seq_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic chip_rst_r, chip_rst_nxt;
  logic gang_r, gang_nxt, self_r, self_nxt;
  logic [1:0] spcnt_r, spcnt_nxt;
  logic [`NPORT-1:0] snr_r, snr_nxt;
  logic src_ok;

  // hold, count 40us, count to strap point, count turnaround, drive
  always_comb begin
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    gang_nxt = gang_r;
    self_nxt = self_r;
    spcnt_nxt = spcnt_r;
    snr_nxt = snr_r;
    src_ok = ext_n_s & pgood_s;
    if (!src_ok) begin
      seq_nxt = hub_cfg_pkg::SEQ_HOLD;
      cnt_nxt = '0;
    end else begin
      case (seq_r)
        hub_cfg_pkg::SEQ_HOLD: begin
          seq_nxt = hub_cfg_pkg::SEQ_POR;
          cnt_nxt = '0;
        end
        hub_cfg_pkg::SEQ_POR: begin
          if (cnt_r == `CNT_W'(`POR_CYC - 1)) begin
            seq_nxt = hub_cfg_pkg::SEQ_STRAP;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        hub_cfg_pkg::SEQ_STRAP: begin
          if (cnt_r == `CNT_W'(`STRAP_CYC - 1)) begin
            gang_nxt = gang_s;
            self_nxt = self_s;
            spcnt_nxt = pcnt_s;
            snr_nxt = nr_s;
            seq_nxt = hub_cfg_pkg::SEQ_TURN;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        hub_cfg_pkg::SEQ_TURN: begin
          if (cnt_r == `CNT_W'(TURN_CYC - 1)) begin
            seq_nxt = hub_cfg_pkg::SEQ_DRIVE;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        hub_cfg_pkg::SEQ_DRIVE: begin
          cnt_nxt = '0;
        end
        default: begin
          seq_nxt = hub_cfg_pkg::SEQ_HOLD;
          cnt_nxt = '0;
        end
      endcase
    end
    chip_rst_nxt = (seq_nxt == hub_cfg_pkg::SEQ_HOLD) | (seq_nxt == hub_cfg_pkg::SEQ_POR);
  end

  // sequence registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      seq_r <= hub_cfg_pkg::SEQ_HOLD;
      cnt_r <= '0;
      chip_rst_r <= 1'b1;
      gang_r <= 1'b0;
      self_r <= 1'b0;
      spcnt_r <= '0;
      snr_r <= '0;
    end else begin
      seq_r <= seq_nxt;
      cnt_r <= cnt_nxt;
      chip_rst_r <= chip_rst_nxt;
      gang_r <= gang_nxt;
      self_r <= self_nxt;
      spcnt_r <= spcnt_nxt;
      snr_r <= snr_nxt;
    end
  end

  // ---- axi4-lite slave ----
  logic [31:0] ctrl_r, ctrl_nxt, led_r, led_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [`AXI_AW-1:0] awaddr_r, awaddr_nxt, waddr;
  logic [31:0] wdata_r, wdata_nxt, wdat;
  logic [3:0] wstrb_r, wstrb_nxt, wstb;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, status;
  logic aw_go, w_go, aw_have, w_have, do_write;
  logic [`NPORT-1:0] active_r, nonrem_r, green_r, amber_r, pwr_n_r;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign status = {12'h000, route_translator, nonrem_r, active_r, oc_n_s, chip_rst_r,
                   ~gang_strap_suspend_pin_oe_n, self_r, gang_r};

  // write once both address and data are in hand, answer next cycle
  always_comb begin
    aw_go = s_axi_awvalid & s_axi_awready;
    w_go = s_axi_wvalid & s_axi_wready;
    aw_have = aw_held_r | aw_go;
    w_have = w_held_r | w_go;
    do_write = aw_have & w_have;
    waddr = aw_held_r ? awaddr_r : s_axi_awaddr;
    wdat = w_held_r ? wdata_r : s_axi_wdata;
    wstb = w_held_r ? wstrb_r : s_axi_wstrb;
    aw_held_nxt = aw_have & ~do_write;
    w_held_nxt = w_have & ~do_write;
    awaddr_nxt = aw_go ? s_axi_awaddr : awaddr_r;
    wdata_nxt = w_go ? s_axi_wdata : wdata_r;
    wstrb_nxt = w_go ? s_axi_wstrb : wstrb_r;
    ctrl_nxt = ctrl_r;
    led_nxt = led_r;
    bresp_nxt = bresp_r;
    bvalid_nxt = bvalid_r & ~s_axi_bready;
    if (do_write) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = `RESP_OKAY;
      case ({waddr[`AXI_AW-1:2], 2'b00})
        `OFF_CTRL: begin
          for (int b = 0; b < 4; b++) begin
            if (wstb[b]) begin
              ctrl_nxt[b*8 +: 8] = wdat[b*8 +: 8];
            end
          end
        end
        `OFF_LED: begin
          for (int b = 0; b < 4; b++) begin
            if (wstb[b]) begin
              led_nxt[b*8 +: 8] = wdat[b*8 +: 8];
            end
          end
        end
        `OFF_STATUS: bresp_nxt = `RESP_OKAY;
        default: bresp_nxt = `RESP_SLVERR;
      endcase
    end
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rvalid_nxt = rvalid_r & ~s_axi_rready;
    if (s_axi_arvalid & s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RESP_OKAY;
      case ({s_axi_araddr[`AXI_AW-1:2], 2'b00})
        `OFF_CTRL: rdata_nxt = ctrl_r;
        `OFF_LED: rdata_nxt = led_r;
        `OFF_STATUS: rdata_nxt = status;
        default: begin
          rdata_nxt = '0;
          rresp_nxt = `RESP_SLVERR;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RST;
      led_r <= `LED_RST;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      led_r <= led_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ---- port configuration, power, indicators ----
  logic [1:0] pcnt_sel;
  logic [`NPORT-1:0] active_nxt, nonrem_nxt, pwr_req, oc_eff, green_nxt, amber_nxt, pwr_n_nxt;
  logic led_auto, resume_r, resume_nxt, pin_out_r, pin_out_nxt, pin_oe_n_r, pin_oe_n_nxt;

  // firmware override beats eeprom, eeprom beats strap
  always_comb begin
    if (ctrl_r[`CTRL_FW_OVR_BIT]) begin
      pcnt_sel = ctrl_r[`CTRL_PCNT_LSB +: 2];
      nonrem_nxt = ctrl_r[`CTRL_NR_LSB +: `NPORT];
    end else if (eeprom_cfg_valid) begin
      pcnt_sel = eeprom_port_count;
      nonrem_nxt = eeprom_nonremovable;
    end else begin
      pcnt_sel = spcnt_r;
      nonrem_nxt = snr_r;
    end
    case (pcnt_sel)
      `PCNT_3: active_nxt = `MASK_3;
      `PCNT_2: active_nxt = `MASK_2;
      default: active_nxt = `MASK_4;
    endcase
    nonrem_nxt = nonrem_nxt & active_nxt;
    pwr_req = ctrl_r[`CTRL_PWR_LSB +: `NPORT];
    led_auto = ctrl_r[`CTRL_LED_AUTO_BIT];
    resume_nxt = global_suspend & wakeup_event & ~chip_rst_r;
    pin_oe_n_nxt = (seq_nxt != hub_cfg_pkg::SEQ_DRIVE);
    pin_out_nxt = ~pin_oe_n_nxt & global_suspend;
  end

  // per-port power, indicators and translator control
  for (genvar i = 0; i < `NPORT; i++) begin : g_port
    logic led_off;
    logic pwr_on;
    assign oc_eff[i] = gang_r ? ~oc_n_s[0] : ~oc_n_s[i];
    assign led_off = chip_rst_r | global_suspend | ~active_r[i];
    assign green_nxt[i] = ~led_off & (led_auto ? (port_enabled[i] & ~oc_eff[i])
                                               : led_r[`LED_GREEN_LSB + i]);
    assign amber_nxt[i] = ~led_off & (led_auto ? oc_eff[i] : led_r[`LED_AMBER_LSB + i]);
    if (i == 0) begin : g_first
      assign pwr_on = ~chip_rst_r & ~oc_eff[i] &
                      (gang_r ? |(pwr_req & active_r) : (pwr_req[i] & active_r[i]));
    end else begin : g_rest
      assign pwr_on = ~chip_rst_r & ~gang_r & ~oc_eff[i] & pwr_req[i] & active_r[i];
    end
    assign pwr_n_nxt[i] = ~pwr_on;

    port_tt_ctrl u_tt (
      .mclk(mclk),
      .rst(rst),
      .upstream_high_speed(upstream_high_speed),
      .port_high_speed(port_high_speed[i]),
      .port_active(active_r[i] & ~chip_rst_r),
      .route_translator(route_translator[i]),
      .route_repeater(route_repeater[i])
    );
  end

  // port output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      active_r <= `MASK_4;
      nonrem_r <= '0;
      green_r <= '0;
      amber_r <= '0;
      pwr_n_r <= '1;
      resume_r <= 1'b0;
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else begin
      active_r <= active_nxt;
      nonrem_r <= nonrem_nxt;
      green_r <= green_nxt;
      amber_r <= amber_nxt;
      pwr_n_r <= pwr_n_nxt;
      resume_r <= resume_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
    end
  end

  assign chip_reset = chip_rst_r;
  assign gang_mode = gang_r;
  assign self_powered = self_r;
  assign active_ports = active_r;
  assign nonremovable_ports = nonrem_r;
  assign port_power_enable_n = pwr_n_r;
  assign port_green_indicator = green_r;
  assign port_amber_indicator = amber_r;
  assign internal_resume = resume_r;
  assign gang_strap_suspend_pin_out = pin_out_r;
  assign gang_strap_suspend_pin_oe_n = pin_oe_n_r;
endmodule : hub_config_port_control

// file: hub_config_port_control_props.sv
// concurrent checks on the hub configuration and port control ports
// bound into hub_config_port_control, single mclk domain, rst synchronous
`timescale 1ns/1ps
`include "hub_cfg_regs.svh"
module hub_config_port_control_props (
  // clock and reset
  input logic mclk,
  input logic rst,
  // chip reset and strap pin
  input logic chip_reset,
  input logic gang_strap_suspend_pin_out,
  input logic gang_strap_suspend_pin_oe_n,
  input logic gang_mode,
  input logic self_powered,
  // hub core status
  input logic global_suspend,
  input logic wakeup_event,
  input logic internal_resume,
  input logic upstream_high_speed,
  input logic [`NPORT-1:0] port_high_speed,
  // port pins and routing
  input logic [`NPORT-1:0] port_power_enable_n,
  input logic [`NPORT-1:0] port_green_indicator,
  input logic [`NPORT-1:0] port_amber_indicator,
  input logic [`NPORT-1:0] route_translator,
  input logic [`NPORT-1:0] route_repeater
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // pin released while chip reset holds
  property p_oe_off; chip_reset |=> gang_strap_suspend_pin_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("strap pin driven in chip reset");
  // pin carries suspend one cycle late
  property p_pin; !gang_strap_suspend_pin_oe_n && $past(!gang_strap_suspend_pin_oe_n) |->
    gang_strap_suspend_pin_out == $past(global_suspend); endproperty
  a_pin: assert property (p_pin) else $error("suspend flag wrong on pin");
  // latched straps frozen once pin drives
  property p_hold; !chip_reset && !gang_strap_suspend_pin_oe_n && $past(!gang_strap_suspend_pin_oe_n) |->
    $stable(gang_mode) && $stable(self_powered); endproperty
  a_hold: assert property (p_hold) else $error("latched strap changed");
  // resume pulse per suspended wakeup
  property p_resume; !$past(rst) |-> internal_resume == $past(global_suspend && wakeup_event && !chip_reset);
  endproperty
  a_resume: assert property (p_resume) else $error("resume pulse mismatch");
  // indicators dark in suspend
  property p_led; global_suspend |=> (port_green_indicator | port_amber_indicator) == 4'h0; endproperty
  a_led: assert property (p_led) else $error("indicator lit in suspend");
  // chip reset removes power and routes
  property p_off; chip_reset |=> port_power_enable_n == 4'hF && (route_repeater | route_translator) == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("port active in chip reset");
  // full speed upstream never uses translators
  property p_fs; !upstream_high_speed |=> route_translator == 4'h0; endproperty
  a_fs: assert property (p_fs) else $error("translator used at full speed");
  // high speed upstream splits by port speed
  property p_hs; upstream_high_speed |=> (route_translator & $past(port_high_speed)) == 4'h0 &&
    (route_repeater & ~$past(port_high_speed)) == 4'h0; endproperty
  a_hs: assert property (p_hs) else $error("route mismatch at high speed");
  // gang mode drives the first enable only
  property p_gang; gang_mode && $past(gang_mode) |-> port_power_enable_n[3:1] == 3'h7; endproperty
  a_gang: assert property (p_gang) else $error("extra enable used in gang mode");
endmodule : hub_config_port_control_props
bind hub_config_port_control hub_config_port_control_props u_props (.*);

// file: upstream_host_model.sv
// behavioural upstream host: link speed, bus suspend and wakeup
// assumes mclk domain; suspend only after three idle cycles
`timescale 1ns/1ps
module upstream_host_model (
  // clock and reset
  input logic mclk,
  input logic rst,
  // bench commands
  input logic want_hs,
  input logic want_suspend,
  input logic want_wake,
  // link status seen by the hub
  output logic upstream_high_speed,
  output logic global_suspend,
  output logic wakeup_event
);
  logic [1:0] idle_r;
  // speed from chirp, suspend after idle count
  always_ff @(posedge mclk) begin
    if (rst) begin
      upstream_high_speed <= 1'b0;
      global_suspend <= 1'b0;
      wakeup_event <= 1'b0;
      idle_r <= 2'h0;
    end else begin
      upstream_high_speed <= want_hs;
      idle_r <= !want_suspend ? 2'h0 : (idle_r == 2'h3 ? idle_r : idle_r + 2'h1);
      global_suspend <= want_suspend && idle_r == 2'h3;
      wakeup_event <= want_wake;
    end
  end
endmodule : upstream_host_model

// file: hub_config_port_control_test.sv
// self-checking bench for the hub configuration and port control block
// assumes 20 MHz mclk, short turnaround parameter, host model on the link
`timescale 1ns/1ps
`include "hub_cfg_regs.svh"
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module hub_config_port_control_test;
  localparam int unsigned TC = 20;
  logic [`AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb, nonremovable_strap, eeprom_nonremovable, port_high_speed, port_enabled, m;
  logic [3:0] active_ports, nonremovable_ports, port_power_enable_n, port_overcurrent_n, port_green_indicator;
  logic [3:0] port_amber_indicator, route_translator, route_repeater;
  logic [1:0] s_axi_bresp, s_axi_rresp, port_count_strap, eeprom_port_count;
  logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, external_reset_n, core_power_good;
  logic chip_reset, strap_lvl, gang_strap_suspend_pin_in, gang_strap_suspend_pin_out, gang_strap_suspend_pin_oe_n;
  logic self_power_strap, eeprom_cfg_valid, global_suspend, wakeup_event, upstream_high_speed;
  logic internal_resume, gang_mode, self_powered, want_hs, want_suspend, want_wake;
  int fails, num_checks, seed, n, i, k;
  // wire level: board strap until the chip drives
  assign gang_strap_suspend_pin_in = gang_strap_suspend_pin_oe_n ? strap_lvl : gang_strap_suspend_pin_out;
  hub_config_port_control #(.TURN_CYC(TC)) uut (.*);
  upstream_host_model host (.*);
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // expected active port mask from a count code
  function automatic logic [3:0] pmask(input logic [1:0] c);
    return c == `PCNT_3 ? `MASK_3 : (c == `PCNT_2 ? `MASK_2 : `MASK_4);
  endfunction : pmask
  function automatic logic [31:0] ctrl(input logic [1:0] pc, input logic fw, input logic au,
                                       input logic [3:0] nr, input logic [3:0] pw);
    return {20'h0, pw, nr, au, fw, pc};
  endfunction : ctrl
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // one transfer, write if w; handshakes and answer looked at before the edge that takes them
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tr, fin;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    for (k = 0; k < 40; k++) begin
      @(negedge mclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      fin = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
      if (fin) `CHK({w ? 32'h0 : s_axi_rdata, w ? s_axi_bresp : s_axi_rresp}, {w ? 32'h0 : d, er})
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (fin) begin
        {s_axi_bready, s_axi_rready} <= 2'h0;
        return;
      end
    end
    fails++;
    conclude();
  endtask : bus
  // bounded wait: 0 chip reset off, 1 pin driving, 2 suspended
  task automatic waitsig(input int w, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge mclk);
      if ((w == 0 && chip_reset === 1'b0) || (w == 1 && gang_strap_suspend_pin_oe_n === 1'b0) ||
          (w == 2 && global_suspend === 1'b1)) return;
    end
    fails++;
    conclude();
  endtask : waitsig
  // drop one reset source, restore, follow the strap sequence
  task automatic boot(input logic g, input logic s, input logic [1:0] pc, input logic [3:0] nr, input logic src);
    @(posedge mclk);
    if (src) core_power_good <= 1'b0;
    else external_reset_n <= 1'b0;
    strap_lvl <= g;
    self_power_strap <= s;
    port_count_strap <= pc;
    nonremovable_strap <= nr;
    repeat (8) @(posedge mclk);
    `CHK({chip_reset, gang_strap_suspend_pin_oe_n, port_power_enable_n}, 6'h3F)
    core_power_good <= 1'b1;
    external_reset_n <= 1'b1;
    waitsig(0, 1000);
    `CHK(n >= `POR_CYC && n <= `POR_CYC + 12, 1'b1)
    repeat (`STRAP_CYC + 3) @(posedge mclk);
    `CHK({gang_mode, self_powered}, {g, s})
    `CHK({active_ports, nonremovable_ports}, {pmask(pc), nr & pmask(pc)})
    strap_lvl <= ~g;
    self_power_strap <= ~s;
    waitsig(1, TC + 10);
    `CHK(n + 3 == TC, 1'b1)
    `CHK({gang_mode, self_powered}, {g, s})
  endtask : boot
  // main sequence
  initial begin
    seed = 54556;
    fails = 0;
    num_checks = 0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {external_reset_n, core_power_good, strap_lvl, self_power_strap} = 4'hF;
    {port_count_strap, nonremovable_strap, eeprom_cfg_valid, eeprom_port_count, eeprom_nonremovable} = '0;
    {want_hs, want_suspend, want_wake, port_high_speed} = '0;
    {port_enabled, port_overcurrent_n} = 8'hFF;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, `OFF_CTRL, `CTRL_RST, `RESP_OKAY);
    bus(1'b0, `OFF_LED, `LED_RST, `RESP_OKAY);
    bus(1'b0, 8'h0C, 32'h0, `RESP_SLVERR);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, `RESP_SLVERR);
    bus(1'b1, `OFF_STATUS, 32'hFFFFFFFF, `RESP_OKAY);
    $display("test registers done");
    boot(1'b1, 1'b1, `PCNT_3, 4'h2, 1'b0);
    bus(1'b1, `OFF_CTRL, ctrl(2'h0, 1'b0, 1'b0, 4'h0, 4'h4), `RESP_OKAY);
    bus(1'b1, `OFF_LED, 32'h000000FF, `RESP_OKAY);
    port_overcurrent_n <= 4'hD;
    repeat (6) @(posedge mclk);
    `CHK({port_power_enable_n, port_green_indicator, port_amber_indicator}, 12'hE77)
    port_overcurrent_n <= 4'hE;
    repeat (6) @(posedge mclk);
    `CHK(port_power_enable_n, 4'hF)
    want_suspend <= 1'b1;
    waitsig(2, 20);
    repeat (2) @(posedge mclk);
    `CHK({gang_strap_suspend_pin_out, port_green_indicator, port_amber_indicator}, 9'h100)
    want_wake <= 1'b1;
    @(posedge mclk);
    want_wake <= 1'b0;
    i = 0;
    repeat (6) begin
      @(negedge mclk);
      if (internal_resume === 1'b1) i++;
    end
    `CHK(i, 1)
    @(posedge mclk);
    want_suspend <= 1'b0;
    $display("test gang done");
    boot(1'b0, 1'b0, 2'h0, 4'h9, 1'b1);
    for (i = 0; i < 12; i++) begin
      r = (i == 0) ? 32'h1FF0F00F : $random(seed);
      bus(1'b1, `OFF_CTRL, ctrl(i[1:0], 1'b1, i[2], r[7:4], r[3:0]), `RESP_OKAY);
      bus(1'b1, `OFF_LED, {24'h0, r[27:20]}, `RESP_OKAY);
      port_overcurrent_n <= r[11:8];
      port_high_speed <= r[15:12];
      port_enabled <= r[19:16];
      want_hs <= r[28];
      want_wake <= r[29];
      repeat (8) @(posedge mclk);
      m = pmask(i[1:0]);
      `CHK({active_ports, nonremovable_ports}, {m, r[7:4] & m})
      `CHK(port_power_enable_n, ~(r[3:0] & m & r[11:8]))
      `CHK(port_green_indicator, i[2] ? r[19:16] & r[11:8] & m : r[23:20] & m)
      `CHK(port_amber_indicator, i[2] ? ~r[11:8] & m : r[27:24] & m)
      `CHK(route_translator, r[28] ? ~r[15:12] & m : 4'h0)
      `CHK(route_repeater, r[28] ? r[15:12] & m : m)
      bus(1'b0, `OFF_STATUS, {12'h0, r[28] ? ~r[15:12] & m : 4'h0, r[7:4] & m, m, r[11:8], 4'h4},
          `RESP_OKAY);
    end
    bus(1'b1, `OFF_CTRL, ctrl(2'h0, 1'b0, 1'b0, 4'h0, 4'hF), `RESP_OKAY);
    eeprom_cfg_valid <= 1'b1;
    eeprom_port_count <= `PCNT_2;
    eeprom_nonremovable <= 4'hF;
    repeat (4) @(posedge mclk);
    `CHK({active_ports, nonremovable_ports}, 8'h33)
    eeprom_cfg_valid <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK({active_ports, nonremovable_ports}, 8'hF9)
    $display("test individual done");
    conclude();
  end
endmodule : hub_config_port_control_test
